// >>> cdto_consts.svh
// Constants for the D-PHY timing override register bank
// What this block does
// RL1 - Zero time uses automatic value when override bit 0, register value when 1
// RL2 - Trail time uses automatic value when override bit 0, register value when 1
// RL3 - Exit time uses automatic value when override bit 0, register value when 1
// RL4 - LP-to-HS transition uses automatic value when bit 0, register value when 1
// RL5 - Override off: value field writes ignored, reads return automatic value
// RL6 - Override on: value field writable, reads return last written value
// RL7 - Reset clears every override bit so automatic values are used
`ifndef CDTO_CONSTS_SVH
`define CDTO_CONSTS_SVH
`define CDTO_IDX_ZERO    8'h45
`define CDTO_IDX_TRAIL   8'h46
`define CDTO_IDX_EXIT    8'h47
`define CDTO_IDX_TPLX    8'h48
`define CDTO_NUM_REGS    4
`define CDTO_OV_BIT      7
`define CDTO_VAL_MSB     6
`define CDTO_VAL_W       7
`define CDTO_RESET_VAL   8'h00
`define CDTO_TRANS_NSEQ  2'b10
`define CDTO_TRANS_SEQ   2'b11
`define CDTO_SIZE_WORD   3'b010
`define CDTO_ADDR_LSB    2
`endif

// >>> cdto_if.sv
// Register file write and read carrier
`timescale 1ns/1ps
`default_nettype none
interface cdto_if;
  import cdto_pkg::*;
  logic         wr_en;
  cdto_sel_type wr_sel;
  logic [7:0]   wr_data;
  logic [7:0]   rd_data [4];
  modport ctrl (output wr_en, wr_sel, wr_data, input rd_data);
  modport regs (input wr_en, wr_sel, wr_data, output rd_data);
endinterface
`default_nettype wire

// >>> cdto_pkg.sv
// Types for the D-PHY timing override register bank
package cdto_pkg;
  typedef logic [6:0] cdto_val_type;
  typedef logic [1:0] cdto_sel_type;
endpackage

// >>> cdto_regs.sv
// Four override registers with their override muxes
`include "cdto_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cdto_regs
  import cdto_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  cdto_if.regs              rf,
  input  wire cdto_val_type auto_val [4],
  output var  logic [3:0]   ov_en,
  output var  cdto_val_type ov_val [4]
);
  // ****************
  // Register storage
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_en <= '0; // RL7
      for (int i = 0; i < `CDTO_NUM_REGS; i++) begin
        ov_val[i] <= '0;
      end
    end else if (rf.wr_en) begin
      ov_en[rf.wr_sel] <= rf.wr_data[`CDTO_OV_BIT];
      // Value field taken only if override stays on after this write
      if (rf.wr_data[`CDTO_OV_BIT]) begin // RL5 RL6
        ov_val[rf.wr_sel] <= rf.wr_data[`CDTO_VAL_MSB:0];
      end
    end
  end

  // ****************
  // Read view
  // ****************
  always_comb begin
    for (int i = 0; i < `CDTO_NUM_REGS; i++) begin
      rf.rd_data[i] = {ov_en[i], ov_en[i] ? ov_val[i] : auto_val[i]}; // RL5 RL6
    end
  end

  property p_reset_clear;
    @(posedge clk) $fell(rst) |-> ov_en == 4'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RL7
    else $error("override bits not cleared by reset");
  property p_set_by_write;
    @(posedge clk) disable iff (rst)
      $rose(ov_en[0]) |-> $past(rf.wr_en) && $past(rf.wr_sel) == 2'd0;
  endproperty
  a_set_by_write: assert property (p_set_by_write) // RL7
    else $error("override bit set without write");
endmodule
`default_nettype wire

// >>> cdto_top.sv
// AHB-Lite slave and timing selection for the override bank
//
// Added by the designer: the AHB-Lite interface to the registers.
`include "cdto_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cdto_top
  import cdto_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output var  logic [31:0]  hrdata,
  output var  logic         hreadyout,
  output var  logic         hresp,
  input  wire cdto_val_type auto_zero,
  input  wire cdto_val_type auto_trail,
  input  wire cdto_val_type auto_exit,
  input  wire cdto_val_type auto_tplx,
  output var  cdto_val_type zero_time,
  output var  cdto_val_type trail_time,
  output var  cdto_val_type exit_time,
  output var  cdto_val_type transition_time
);
  cdto_if rf ();
  logic [3:0]   ov_en;
  cdto_val_type ov_val [4];
  cdto_val_type auto_val [4];
  logic         wr_pend_reg;
  cdto_sel_type wr_sel_reg;
  logic         rd_pend_reg;
  cdto_sel_type rd_sel_reg;
  logic         rd_hit_reg;

  // ****************
  // Decode
  // ****************
  function automatic logic hit(input logic [31:0] a);
    logic [29:0] idx;
    idx = a[31:`CDTO_ADDR_LSB];
    hit = (a[1:0] == 2'h0) && idx >= 30'(`CDTO_IDX_ZERO) && idx <= 30'(`CDTO_IDX_TPLX);
  endfunction

  function automatic cdto_sel_type sel(input logic [31:0] a);
    logic [7:0] d;
    d = a[9:2] - `CDTO_IDX_ZERO;
    sel = d[1:0];
  endfunction

  logic take;
  assign take = hsel && hready && (htrans == `CDTO_TRANS_NSEQ || htrans == `CDTO_TRANS_SEQ);

  assign auto_val[0] = auto_zero;
  assign auto_val[1] = auto_trail;
  assign auto_val[2] = auto_exit;
  assign auto_val[3] = auto_tplx;

  // ****************
  // Bus phases
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg  <= '0;
      rd_pend_reg <= 1'b0;
      rd_sel_reg  <= '0;
      rd_hit_reg  <= 1'b0;
    end else begin
      wr_pend_reg <= take && hwrite && hit(haddr);
      wr_sel_reg  <= sel(haddr);
      rd_pend_reg <= take && !hwrite;
      rd_sel_reg  <= sel(haddr);
      rd_hit_reg  <= hit(haddr);
    end
  end

  assign rf.wr_en   = wr_pend_reg;
  assign rf.wr_sel  = wr_sel_reg;
  assign rf.wr_data = hwdata[7:0];

  // Read data register: loaded on the edge that samples the address so hrdata is a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (take && !hwrite) begin
      hrdata <= hit(haddr) ? {24'h0, rf.rd_data[sel(haddr)]} : 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  cdto_regs u_regs (
    .clk      (clk),
    .rst      (rst),
    .rf       (rf.regs),
    .auto_val (auto_val),
    .ov_en    (ov_en),
    .ov_val   (ov_val)
  );

  // ****************
  // Timing selection
  // ****************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_time       <= '0;
      trail_time      <= '0;
      exit_time       <= '0;
      transition_time <= '0;
    end else begin
      zero_time       <= ov_en[0] ? ov_val[0] : auto_zero;  // RL1
      trail_time      <= ov_en[1] ? ov_val[1] : auto_trail; // RL2
      exit_time       <= ov_en[2] ? ov_val[2] : auto_exit;  // RL3
      transition_time <= ov_en[3] ? ov_val[3] : auto_tplx;  // RL4
    end
  end

  // ****************
  // Checks
  // ****************
  property p_zero_sel;
    @(posedge clk) disable iff (rst) ##1 1 |-> zero_time == $past(ov_en[0] ? ov_val[0] : auto_zero);
  endproperty
  a_zero_sel: assert property (p_zero_sel) else $error("zero time wrong source"); // RL1
  property p_trail_sel;
    @(posedge clk) disable iff (rst) !ov_en[1] |=> trail_time == $past(auto_trail);
  endproperty
  a_trail_sel: assert property (p_trail_sel) else $error("trail time wrong source"); // RL2
  property p_exit_sel;
    @(posedge clk) disable iff (rst) ov_en[2] |=> exit_time == $past(ov_val[2]);
  endproperty
  a_exit_sel: assert property (p_exit_sel) else $error("exit time wrong source"); // RL3
  property p_tplx_sel;
    @(posedge clk) disable iff (rst) ov_en[3] |=> transition_time == $past(ov_val[3]);
  endproperty
  a_tplx_sel: assert property (p_tplx_sel) else $error("transition time wrong source"); // RL4
  property p_off_ignore;
    @(posedge clk) disable iff (rst)
      wr_pend_reg && !hwdata[`CDTO_OV_BIT] |=>
        ov_val[$past(wr_sel_reg)] == $past(ov_val[wr_sel_reg]);
  endproperty
  a_off_ignore: assert property (p_off_ignore) else $error("value written while off"); // RL5
  property p_on_store;
    @(posedge clk) disable iff (rst)
      wr_pend_reg && hwdata[`CDTO_OV_BIT] |=> ov_val[$past(wr_sel_reg)] == $past(hwdata[6:0]);
  endproperty
  a_on_store: assert property (p_on_store) else $error("value not stored"); // RL6
  property p_rd_auto;
    @(posedge clk) disable iff (rst)
      take && !hwrite && hit(haddr) && !ov_en[sel(haddr)] |=> hrdata[7] == 1'b0;
  endproperty
  a_rd_auto: assert property (p_rd_auto) else $error("read of off register shows bit set"); // RL5
  property p_rst_auto;
    @(posedge clk) $fell(rst) |-> ov_en == 4'h0 ##1 zero_time == $past(auto_zero);
  endproperty
  a_rst_auto: assert property (p_rst_auto) else $error("reset left override on"); // RL7
  property p_zero_on;
    @(posedge clk) disable iff (rst) ov_en[0] |=> zero_time == $past(ov_val[0]);
  endproperty
  a_zero_on: assert property (p_zero_on) else $error("zero time ignores override"); // RL1
  property p_trail_on;
    @(posedge clk) disable iff (rst) ov_en[1] |=> trail_time == $past(ov_val[1]);
  endproperty
  a_trail_on: assert property (p_trail_on) else $error("trail time ignores override"); // RL2
  property p_exit_off;
    @(posedge clk) disable iff (rst) !ov_en[2] |=> exit_time == $past(auto_exit);
  endproperty
  a_exit_off: assert property (p_exit_off) else $error("exit time ignores auto"); // RL3
  property p_tplx_off;
    @(posedge clk) disable iff (rst) !ov_en[3] |=> transition_time == $past(auto_tplx);
  endproperty
  a_tplx_off: assert property (p_tplx_off) else $error("transition ignores auto"); // RL4
  property p_rst_outputs;
    @(posedge clk) $fell(rst) |-> hrdata == 32'h0 && hreadyout && !hresp && zero_time == '0;
  endproperty
  a_rst_outputs: assert property (p_rst_outputs) else $error("outputs not reset"); // RL7

  // ****************
  // Read checks
  // ****************
  property p_rd_unmapped;
    @(posedge clk) disable iff (rst) rd_pend_reg && !rd_hit_reg |-> hrdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_rd_upper;
    @(posedge clk) disable iff (rst) rd_pend_reg |-> hrdata[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits not zero");
  property p_rd_flag;
    @(posedge clk) disable iff (rst)
      rd_pend_reg && rd_hit_reg && !$past(wr_pend_reg) |-> hrdata[7] == ov_en[rd_sel_reg];
  endproperty
  a_rd_flag: assert property (p_rd_flag) else $error("read flag wrong"); // RL5 RL6
  property p_rd_on;
    @(posedge clk) disable iff (rst)
      take && !hwrite && hit(haddr) && ov_en[sel(haddr)] |=>
        hrdata[6:0] == $past(ov_val[sel(haddr)]);
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("read of on register wrong"); // RL6
  property p_rd_off_val;
    @(posedge clk) disable iff (rst)
      take && !hwrite && hit(haddr) && !ov_en[sel(haddr)] |=>
        hrdata[6:0] == $past(auto_val[sel(haddr)]);
  endproperty
  a_rd_off_val: assert property (p_rd_off_val) else $error("read of off register wrong"); // RL5
endmodule
`default_nettype wire

// >>> tb_csi_dphy_timing_override.sv
// Self-checking bench for the timing override register bank
`include "cdto_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_csi_dphy_timing_override;
  import cdto_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} cdto_row_type;
  localparam cdto_row_type ROWS [8] = '{'{8'h45, 8'h85, 8'h85}, '{8'h46, 8'hff, 8'hff},
    '{8'h47, 8'h80, 8'h80}, '{8'h48, 8'haa, 8'haa}, '{8'h45, 8'h7f, 8'h11},
    '{8'h46, 8'h00, 8'h22}, '{8'h47, 8'h7a, 8'h33}, '{8'h48, 8'h2a, 8'h44}};
  logic         clk;
  logic         rst;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  cdto_val_type auto_v [4];
  cdto_val_type tim [4];
  logic [31:0]  rd;
  int           bad_count;
  int           checks;
  cdto_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(`CDTO_SIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .auto_zero(auto_v[0]),
    .auto_trail(auto_v[1]), .auto_exit(auto_v[2]), .auto_tplx(auto_v[3]),
    .zero_time(tim[0]), .trail_time(tim[1]), .exit_time(tim[2]),
    .transition_time(tim[3]));
  always #12.5 clk = ~clk;
  // ********************
  // Bus and check tasks
  // ********************
  task complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wait_ready;
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        bad_count++;
        complete_run();
      end
      @(posedge clk);
    end
  endtask
  task xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= `CDTO_TRANS_NSEQ;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
    rd = hrdata;
    chk("response", {31'h0, hresp}, 32'h0);
    chk("ready", {31'h0, hreadyout}, 32'h1);
  endtask
  task rd_all;
    for (int k = 0; k < 4; k++) begin
      xfer(`CDTO_IDX_ZERO + 8'(k), 1'b0, 8'h00);
      chk("auto read", rd, {25'h0, auto_v[k]});
      chk("auto timing", {25'h0, tim[k]}, {25'h0, auto_v[k]});
    end
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    int k;
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    auto_v = '{7'h11, 7'h22, 7'h33, 7'h44};
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_all();
    for (int i = 0; i < 8; i++) begin
      k = int'(ROWS[i].idx) - int'(`CDTO_IDX_ZERO);
      xfer(ROWS[i].idx, 1'b1, ROWS[i].wd);
      xfer(ROWS[i].idx, 1'b0, 8'h00);
      chk("readback", rd, {24'h0, ROWS[i].exp});
      chk("timing", {25'h0, tim[k]}, {25'h0, ROWS[i].exp[6:0]});
    end
    xfer(`CDTO_IDX_ZERO, 1'b1, 8'h9c);
    auto_v[0] <= 7'h55;
    xfer(`CDTO_IDX_ZERO, 1'b0, 8'h00);
    chk("held override", rd, 32'h9c);
    chk("held timing", {25'h0, tim[0]}, 32'h1c);
    auto_v[1] <= 7'h6b;
    xfer(`CDTO_IDX_TRAIL, 1'b0, 8'h00);
    chk("auto follows", rd, 32'h6b);
    chk("auto timing", {25'h0, tim[1]}, 32'h6b);
    xfer(8'h49, 1'b1, 8'hff);
    xfer(8'h49, 1'b0, 8'h00);
    chk("unmapped", rd, 32'h0);
    xfer(`CDTO_IDX_EXIT, 1'b1, 8'hc1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset timing", {25'h0, tim[2]}, 32'h0);
    chk("reset zero", {25'h0, tim[0]}, 32'h0);
    chk("reset trail", {25'h0, tim[1]}, 32'h0);
    chk("reset transition", {25'h0, tim[3]}, 32'h0);
    chk("reset rdata", hrdata, 32'h0);
    chk("reset ready", {31'h0, hreadyout}, 32'h1);
    rst <= 1'b0;
    @(posedge clk);
    rd_all();
    complete_run();
  end
endmodule
`default_nettype wire
